// ### bench/emtbu_core_model.sv
// Purpose: Emulated core stepping instructions into the unit.
// Assumes: Caller spaces steps; each step holds pc a cycle after.
// Notes:   All core state except pc and the strobes derives from one 8-bit value k.
`timescale 1ns/1ps
`default_nettype none
module emtbu_core_model (
  // Clock
  input  wire logic  mclk,
  // Core state
  output logic       inst_go,
  output logic       mcyc,
  output logic       pwr_dn_set,
  output logic [14:0] pc,
  output logic [7:0] k
);
  // Idle core at start
  initial begin
    {inst_go, mcyc, pwr_dn_set, pc, k} = '0;
  end
  // One instruction, pc held, two idle cycles between back-to-back steps
  task automatic step(input logic [14:0] p, input logic [7:0] v, input logic pd);
    @(posedge mclk);
    inst_go <= 1'b1;
    mcyc <= 1'b1;
    pwr_dn_set <= pd;
    pc <= p;
    k <= v;
    @(posedge mclk);
    {inst_go, mcyc, pwr_dn_set} <= 3'h0;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### bench/emtbu_monitor.sv
// Purpose: Port checks of the trace and break unit.
// Assumes: Bound to emtbu_top, one clock, async active-low reset.
// Notes:   Watches bus handshakes and the run/break outputs.
`timescale 1ns/1ps
`default_nettype none
module emtbu_monitor
  import emtbu_pkg::*;
(
  // Clock, reset
  input wire logic        mclk,
  input wire logic        nrst,
  // Bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Run control
  input wire logic        pwr_dn_set,
  input wire logic        emu_run,
  input wire logic        brk_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Break pulse comes with the stop and lasts one cycle
  brk_stop_a: assert property (brk_pulse |-> !emu_run && $past(emu_run))
    else $error("break pulse without a stop");
  brk_once_a: assert property (brk_pulse |=> !brk_pulse)
    else $error("break pulse too long");
  pdn_brk_a: assert property (pwr_dn_set && emu_run |-> ##[1:3] brk_pulse)
    else $error("no break on power-down entry");
  // Answers stand until taken, no new request while answering, error reads carry zero data
  b_hold_a: assert property (s_axi_bvalid |=> $past(s_axi_bready) || $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid |=> $past(s_axi_rready) || $stable(s_axi_rdata))
    else $error("read answer dropped");
  b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp != RESP_OKAY |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
endmodule
bind emtbu_top emtbu_monitor i_mon (.mclk(mclk), .nrst(nrst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .pwr_dn_set(pwr_dn_set), .emu_run(emu_run),
  .brk_pulse(brk_pulse));
`default_nettype wire

// ### bench/testbench.sv
// Purpose: Self-checking bench of the trace and break unit.
// Assumes: Bus master tasks, core model, bound checker.
// Notes:   Memories cleared by software before use.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import emtbu_pkg::*;
  logic        mclk, nrst, awvalid, wvalid, bready, arvalid, rready, probe_ext;
  logic        awready, wready, bvalid, arready, rvalid, emu_run, brk_pulse;
  logic        inst_go, mcyc, pdn;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  awaddr, araddr, ck;
  logic [14:0] pc;
  logic [31:0] wdata, rdata, rv;
  logic [66:0] e;
  int          err_count, n_compared;
  emtbu_core_model i_core (.mclk(mclk), .inst_go(inst_go), .mcyc(mcyc),
    .pwr_dn_set(pdn), .pc(pc), .k(ck));
  emtbu_top i_emtbu_top (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .inst_go(inst_go), .program_counter(pc), .dm_valid(ck[0]), .dm_addr({4'h0, ck}),
    .dm_data(ck[3:0]), .reg_a(ck[7:4]), .reg_b(ck[3:0]), .reg_h(~ck[7:4]),
    .reg_l(~ck[3:0]), .reg_x(ck[3:0]), .reg_y(ck[7:4]), .stack_top_pointer(ck),
    .port_bus({8{ck[3:0]}}), .sign_result_flag(ck[3]), .carry(ck[2]),
    .vector_entry_cycle_flag(ck[1]), .suppressed_execution_flag(ck[0]), .mcyc(mcyc),
    .pwr_dn_set(pdn), .probe_val(ck), .probe_ext(probe_ext), .emu_run(emu_run),
    .brk_pulse(brk_pulse));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk({30'h0, bresp}, {30'h0, x});
  endtask
  // Bus read into rv and rs
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rs = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    rd(a);
    chk(rv, x);
  endtask
  // Clear breakpoint, trace enable and marker of one address
  task automatic prep(input logic [14:0] p);
    wr(OFS_CIDX, {17'h0, p}, RESP_OKAY);
    wr(OFS_ATTR, 32'h8, RESP_OKAY);
  endtask
  task automatic t_reset;
    rc(OFS_MASK, 32'h1f);
    rc(OFS_LIMIT, 32'h0fff7fff);
    rd(8'hfc);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(8'hfc, 32'h0, RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_trace;
    prep(15'h1234);
    wr(OFS_CTRL, 32'h11, RESP_OKAY);
    i_core.step(15'h1234, 8'h12, 1'b0);
    rc(OFS_TPTR, 32'h1);
    wr(OFS_CTRL, 32'h5, RESP_OKAY);
    i_core.step(15'h1234, 8'h5a, 1'b0);
    rc(OFS_TPTR, 32'h1);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    e = {15'h1234, 12'h012, 4'h2, 4'h1, 4'h2, 4'h2, 4'h1, 8'h12, 4'h2, 4'h2, 4'h2};
    wr(OFS_TIDX, 32'h0, RESP_OKAY);
    repeat (2) @(posedge mclk);
    rc(OFS_TDAT0, e[31:0]);
    rc(OFS_TDAT1, e[63:32]);
    rc(OFS_TDAT2, {29'h0, e[66:64]});
    wr(OFS_CIDX, 32'h1234, RESP_OKAY);
    repeat (2) @(posedge mclk);
    rd(OFS_ATTR);
    chk({31'h0, rv[2]}, 32'h1);
    $display("trace test done");
  endtask
  task automatic t_ext;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    probe_ext <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, emu_run}, 32'h0);
    rd(OFS_STAT);
    chk({31'h0, rv[12]}, 32'h1);
    probe_ext <= 1'b0;
    wr(OFS_MASK, 32'h0f, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    probe_ext <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, emu_run}, 32'h1);
    probe_ext <= 1'b0;
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    $display("external break test done");
  endtask
  task automatic t_pdn;
    prep(15'h0100);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    i_core.step(15'h0100, 8'h00, 1'b1);
    repeat (3) @(posedge mclk);
    chk({31'h0, emu_run}, 32'h0);
    rd(OFS_STAT);
    chk({31'h0, rv[13]}, 32'h1);
    $display("power-down test done");
  endtask
  // Pre-trigger: match instruction recorded, then recording stops
  task automatic t_pre;
    wr(OFS_MATCH, 32'h77, RESP_OKAY);
    wr(OFS_CTRL, 32'h0b, RESP_OKAY);
    rd(OFS_TPTR);
    i_core.step(15'h0100, 8'h77, 1'b0);
    i_core.step(15'h0100, 8'h00, 1'b0);
    rc(OFS_TPTR, rv + 32'h1);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    $display("pre-trigger test done");
  endtask
  // Breakpoint bit break, then out-of-range break
  task automatic t_brk;
    wr(OFS_CIDX, 32'h0200, RESP_OKAY);
    wr(OFS_ATTR, 32'h9, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    i_core.step(15'h0200, 8'h00, 1'b0);
    rc(OFS_STAT, 32'h0100);
    wr(OFS_ATTR, 32'h0, RESP_OKAY);
    wr(OFS_LIMIT, 32'h0fff01ff, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    i_core.step(15'h0200, 8'h00, 1'b0);
    rc(OFS_STAT, 32'h4000);
    $display("break test done");
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    conclude;
  end
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, probe_ext, nrst} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_trace;
    t_ext;
    t_pdn;
    t_pre;
    t_brk;
    conclude;
  end
endmodule
`default_nettype wire

// ### hw/emtbu_mem.sv
// Purpose: Simple one-write one-read memory with registered read data.
// Assumes: Write and read ports share the clock.
// Notes:   Used for trace entries, address attributes and executed marks.
`timescale 1ns/1ps
`default_nettype none
module emtbu_mem #(
  parameter int W = 1,
  parameter int A = 15
) (
  // Clock
  input  wire logic         mclk,
  // Write port
  input  wire logic         we,
  input  wire logic [A-1:0] waddr,
  input  wire logic [W-1:0] wdata,
  // Read port
  input  wire logic [A-1:0] raddr,
  output logic      [W-1:0] rdata
);
  // Refuse shapes the array cannot hold
  if (W < 1 || A < 1 || A > 20) begin : g_chk
    $error("emtbu_mem: bad width or depth");
  end

  logic [W-1:0] mem [2**A];

  // Write, then registered read
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ### hw/emtbu_pass_ctr.sv
// Purpose: One address visit counter with its watched address.
// Assumes: Step pulses once per executed instruction.
// Notes:   Overflow pulse arrives one cycle after the step.
`timescale 1ns/1ps
`default_nettype none
module emtbu_pass_ctr
  import emtbu_pkg::*;
(
  // Clock, reset
  input  wire logic            mclk,
  input  wire logic            nrst,
  // Configuration
  input  wire logic            cfg_we,
  input  wire logic [PC_W-1:0] cfg_addr,
  // Execution
  input  wire logic            step,
  input  wire logic [PC_W-1:0] pc,
  // Results
  output logic      [AP_W-1:0] cnt,
  output logic      [PC_W-1:0] addr,
  output logic                 ovf
);
  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic [AP_W-1:0] cnt;
    logic            ovf;
  } emtbu_pc_s;

  emtbu_pc_s s_r;
  emtbu_pc_s s_nxt;

  // Count visits, flag wrap
  always_comb begin
    s_nxt = s_r;
    s_nxt.ovf = 1'b0;
    if (step && pc == s_r.addr) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      s_nxt.ovf = &s_r.cnt;
    end
    if (cfg_we) begin
      s_nxt.addr = cfg_addr;
      s_nxt.cnt  = '0;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cnt  = s_r.cnt;
  assign addr = s_r.addr;
  assign ovf  = s_r.ovf;
endmodule
`default_nettype wire

// ### hw/emtbu_pkg.sv
// Purpose: Shared constants of the emulator trace and break unit.
// Assumes: One 32-bit AXI4-Lite register space, byte addressed.
// Notes:   Offsets, field widths, reset values and mode codes.
package emtbu_pkg;
  // Field widths of the emulated core, the trace, the counters and the bus
  localparam int PC_W  = 15;
  localparam int DA_W  = 12;
  localparam int NB_W  = 4;
  localparam int SP_W  = 8;
  localparam int PR_W  = 8;
  localparam int TP_W  = 13;
  localparam int CY_W  = 32;
  localparam int AP_W  = 16;
  localparam int AP_N  = 4;
  localparam int AX_AW = 8;
  localparam int ENT_W = PC_W + DA_W + 7 * NB_W + SP_W + 4;

  // Register byte offsets
  localparam logic [AX_AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AX_AW-1:0] OFS_STAT   = 8'h04;
  localparam logic [AX_AW-1:0] OFS_MASK   = 8'h08;
  localparam logic [AX_AW-1:0] OFS_TSTART = 8'h0c;
  localparam logic [AX_AW-1:0] OFS_TSTOP  = 8'h10;
  localparam logic [AX_AW-1:0] OFS_MATCH  = 8'h14;
  localparam logic [AX_AW-1:0] OFS_GADDR  = 8'h18;
  localparam logic [AX_AW-1:0] OFS_GSEQ   = 8'h1c;
  localparam logic [AX_AW-1:0] OFS_GDATA  = 8'h20;
  localparam logic [AX_AW-1:0] OFS_GEN    = 8'h24;
  localparam logic [AX_AW-1:0] OFS_LIMIT  = 8'h28;
  localparam logic [AX_AW-1:0] OFS_TPTR   = 8'h2c;
  localparam logic [AX_AW-1:0] OFS_CYCLE  = 8'h30;
  localparam logic [AX_AW-1:0] OFS_PASS0  = 8'h34;
  localparam logic [AX_AW-1:0] OFS_TIDX   = 8'h44;
  localparam logic [AX_AW-1:0] OFS_TDAT0  = 8'h48;
  localparam logic [AX_AW-1:0] OFS_TDAT1  = 8'h4c;
  localparam logic [AX_AW-1:0] OFS_TDAT2  = 8'h50;
  localparam logic [AX_AW-1:0] OFS_CIDX   = 8'h54;
  localparam logic [AX_AW-1:0] OFS_ATTR   = 8'h58;

  // Trace control modes
  localparam logic [2:0] TM_FREE = 3'h0;
  localparam logic [2:0] TM_ENB  = 3'h1;
  localparam logic [2:0] TM_OFF  = 3'h2;
  localparam logic [2:0] TM_TRIG = 3'h3;
  localparam logic [2:0] TM_POST = 3'h4;
  localparam logic [2:0] TM_PRE  = 3'h5;

  // Reset values
  localparam logic [PC_W-1:0] CODE_MAX_RST = 15'h7fff;
  localparam logic [DA_W-1:0] DM_MAX_RST   = 12'hfff;
  localparam logic [4:0]      MASK_RST     = 5'h1f;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### hw/emtbu_top.sv
// Purpose: Trace, break and coverage unit of an in-circuit emulator.
// Assumes: Core inputs are synchronous to mclk; inst_go marks each start.
// Notes:   Stage 1 latches an instruction, stage 2 decides trace and breaks.
`timescale 1ns/1ps
`default_nettype none
module emtbu_top
  import emtbu_pkg::*;
(
  // Clock, reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // AXI4-Lite write
  input  wire logic [AX_AW-1:0] s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic      [1:0]       s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AX_AW-1:0] s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic      [31:0]      s_axi_rdata,
  output logic      [1:0]       s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Emulated core
  input  wire logic             inst_go,
  input  wire logic [PC_W-1:0]  program_counter,
  input  wire logic             dm_valid,
  input  wire logic [DA_W-1:0]  dm_addr,
  input  wire logic [NB_W-1:0]  dm_data,
  input  wire logic [NB_W-1:0]  reg_a,
  input  wire logic [NB_W-1:0]  reg_b,
  input  wire logic [NB_W-1:0]  reg_h,
  input  wire logic [NB_W-1:0]  reg_l,
  input  wire logic [NB_W-1:0]  reg_x,
  input  wire logic [NB_W-1:0]  reg_y,
  input  wire logic [SP_W-1:0]  stack_top_pointer,
  input  wire logic [8*NB_W-1:0] port_bus,
  input  wire logic             sign_result_flag,
  input  wire logic             carry,
  input  wire logic             vector_entry_cycle_flag,
  input  wire logic             suppressed_execution_flag,
  input  wire logic             mcyc,
  input  wire logic             pwr_dn_set,
  // Probe cable
  input  wire logic [PR_W-1:0]  probe_val,
  input  wire logic             probe_ext,
  // Emulation control
  output logic                  emu_run,
  output logic                  brk_pulse
);
  typedef struct packed {
    logic             awready, wready, bvalid, arready, rvalid;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata;
    logic [AX_AW-1:0] waddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             aw_ok, w_ok;
    logic             run;
    logic [14:0]      ctrl;
    logic [4:0]       mask;
    logic [7:0]       cause;
    logic [PC_W-1:0]  t_start, t_stop;
    logic [PR_W-1:0]  m_val;
    logic [DA_W-1:0]  m_addr;
    logic [PC_W-1:0]  ga_addr;
    logic [AP_W-1:0]  ga_cnt, ga_hits;
    logic [PC_W-1:0]  sq_a, sq_b;
    logic             sq_arm;
    logic [DA_W-1:0]  gd_addr;
    logic [NB_W-1:0]  gd_val;
    logic [PR_W-1:0]  gp_val;
    logic [3:0]       gen;
    logic [PC_W-1:0]  code_max;
    logic [DA_W-1:0]  dm_max;
    logic [TP_W-1:0]  tptr, tidx;
    logic             tr_on;
    logic [CY_W-1:0]  cyc;
    logic [PC_W-1:0]  cidx;
    logic             p_v;
    logic [ENT_W-1:0] p_ent;
    logic             p_start, p_stop, p_match, p_ga, p_sqa, p_sqb, p_gd, p_gp, p_nacc;
    logic             ext_q, brk;
  } emtbu_state_s;

  localparam emtbu_state_s S_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                     mask: MASK_RST, code_max: CODE_MAX_RST,
                                     dm_max: DM_MAX_RST, default: '0};

  emtbu_state_s s_r;
  emtbu_state_s s_nxt;

  logic [ENT_W-1:0] tr_rd;
  logic [1:0]       attr_rd;
  logic             mark_rd;
  logic [AP_W-1:0]  ap_cnt  [AP_N];
  logic [PC_W-1:0]  ap_addr [AP_N];
  logic             ap_ovf  [AP_N];
  logic [AP_N-1:0]  ap_we;
  logic             do_wr, step, tw_en, attr_we, mark_we;

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Nibble of the selected port
  function automatic logic [NB_W-1:0] port_sel(input logic [2:0] p);
    return port_bus[NB_W*p +: NB_W];
  endfunction

  // Register decode: {mapped, value}
  function automatic logic [32:0] rmux(input logic [AX_AW-1:0] a);
    logic [AX_AW-1:0] w;
    logic [32:0]      r;
    w = {a[AX_AW-1:2], 2'b00};
    r = {1'b1, 32'h0};
    case (w)
      OFS_CTRL:   r[31:0] = {17'h0, s_r.ctrl[14:1], s_r.run};
      OFS_STAT:   r[31:0] = {16'h0, s_r.cause, 7'h0, s_r.run};
      OFS_MASK:   r[31:0] = {27'h0, s_r.mask};
      OFS_TSTART: r[31:0] = {17'h0, s_r.t_start};
      OFS_TSTOP:  r[31:0] = {17'h0, s_r.t_stop};
      OFS_MATCH:  r[31:0] = {4'h0, s_r.m_addr, 8'h0, s_r.m_val};
      OFS_GADDR:  r[31:0] = {s_r.ga_cnt, 1'b0, s_r.ga_addr};
      OFS_GSEQ:   r[31:0] = {1'b0, s_r.sq_b, 1'b0, s_r.sq_a};
      OFS_GDATA:  r[31:0] = {s_r.gp_val, 4'h0, s_r.gd_val, 4'h0, s_r.gd_addr};
      OFS_GEN:    r[31:0] = {28'h0, s_r.gen};
      OFS_LIMIT:  r[31:0] = {4'h0, s_r.dm_max, 1'b0, s_r.code_max};
      OFS_TPTR:   r[31:0] = {19'h0, s_r.tptr};
      OFS_CYCLE:  r[31:0] = s_r.cyc;
      OFS_TIDX:   r[31:0] = {19'h0, s_r.tidx};
      OFS_TDAT0:  r[31:0] = tr_rd[31:0];
      OFS_TDAT1:  r[31:0] = tr_rd[63:32];
      OFS_TDAT2:  r[31:0] = {29'h0, tr_rd[ENT_W-1:64]};
      OFS_CIDX:   r[31:0] = {17'h0, s_r.cidx};
      OFS_ATTR:   r[31:0] = {29'h0, mark_rd, attr_rd};
      default: begin
        r = '0;
        for (int i = 0; i < AP_N; i++) begin
          if (w == OFS_PASS0 + AX_AW'(4 * i)) begin
            r = {2'b10, ap_addr[i], ap_cnt[i]};
          end
        end
      end
    endcase
    return r;
  endfunction

  // Strobes shared with the memories and counters
  always_comb begin
    do_wr   = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
    step    = inst_go && s_r.run;
    attr_we = do_wr && s_r.waddr[AX_AW-1:2] == OFS_ATTR[AX_AW-1:2] && !s_r.run;
    mark_we = step || (attr_we && s_r.wdata[3]);
    for (int i = 0; i < AP_N; i++) begin
      ap_we[i] = do_wr && {s_r.waddr[AX_AW-1:2], 2'b00} == OFS_PASS0 + AX_AW'(4 * i);
    end
  end

  // Next state
  always_comb begin
    logic [32:0]     wv;
    logic            rec, on_now, g_hit, full;
    logic [7:0]      ev;
    logic [7:0]      ev_en;
    logic [2:0]      mode;
    logic [AP_W:0]   hits1;
    logic [NB_W-1:0] i1, i2;
    wv     = '0;
    rec    = 1'b0;
    on_now = 1'b0;
    g_hit  = 1'b0;
    full   = 1'b0;
    ev     = '0;
    ev_en  = '0;
    mode   = s_r.ctrl[3:1];
    hits1  = {1'b0, s_r.ga_hits} + 1'b1;
    i1     = s_r.ctrl[4] ? reg_x : reg_h;
    i2     = s_r.ctrl[4] ? reg_y : reg_l;
    s_nxt  = s_r;
    s_nxt.brk   = 1'b0;
    s_nxt.ext_q = probe_ext;
    tw_en  = 1'b0;

    // Bus write and read channels
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.waddr   = s_axi_awaddr;
      s_nxt.aw_ok   = 1'b1;
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
      s_nxt.w_ok   = 1'b1;
      s_nxt.wready = 1'b0;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end
    if (s_axi_arvalid && s_r.arready) begin
      wv            = rmux(s_axi_araddr);
      s_nxt.rdata   = wv[31:0];
      s_nxt.rresp   = wv[32] ? RESP_OKAY : RESP_SLVERR;
      s_nxt.rvalid  = 1'b1;
      s_nxt.arready = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Register writes
    if (do_wr) begin
      wv = rmux(s_r.waddr);
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wv[32] ? RESP_OKAY : RESP_SLVERR;
      wv[31:0] = wmerge(wv[31:0], s_r.wdata, s_r.wstrb);
      case ({s_r.waddr[AX_AW-1:2], 2'b00})
        OFS_CTRL: begin
          s_nxt.ctrl = wv[14:0];
          s_nxt.run  = wv[0];
          if (wv[0] && !s_r.run) begin
            s_nxt.cause   = '0;
            s_nxt.tr_on   = wv[3:1] == TM_PRE;
            s_nxt.ga_hits = '0;
            s_nxt.sq_arm  = 1'b0;
          end
        end
        OFS_MASK:   s_nxt.mask = wv[4:0];
        OFS_TSTART: s_nxt.t_start = wv[PC_W-1:0];
        OFS_TSTOP:  s_nxt.t_stop = wv[PC_W-1:0];
        OFS_MATCH: begin
          s_nxt.m_val  = wv[7:0];
          s_nxt.m_addr = wv[16 +: DA_W];
        end
        OFS_GADDR: begin
          s_nxt.ga_addr = wv[PC_W-1:0];
          s_nxt.ga_cnt  = wv[31:16];
        end
        OFS_GSEQ: begin
          s_nxt.sq_a = wv[PC_W-1:0];
          s_nxt.sq_b = wv[16 +: PC_W];
        end
        OFS_GDATA: begin
          s_nxt.gd_addr = wv[DA_W-1:0];
          s_nxt.gd_val  = wv[16 +: NB_W];
          s_nxt.gp_val  = wv[31:24];
        end
        OFS_GEN: s_nxt.gen = wv[3:0];
        OFS_LIMIT: begin
          s_nxt.code_max = wv[PC_W-1:0];
          s_nxt.dm_max   = wv[16 +: DA_W];
        end
        OFS_CYCLE: s_nxt.cyc = '0;
        OFS_TIDX:  s_nxt.tidx = wv[TP_W-1:0];
        OFS_CIDX:  s_nxt.cidx = wv[PC_W-1:0];
        default: ;
      endcase
    end

    // Stage 1: latch the executed instruction and its match terms
    s_nxt.p_v = step;
    if (step) begin
      s_nxt.p_ent = {program_counter, dm_addr, dm_data, reg_a, reg_b, i1, i2,
                     stack_top_pointer, port_sel(s_r.ctrl[10:8]),
                     port_sel(s_r.ctrl[14:12]), sign_result_flag, carry,
                     vector_entry_cycle_flag, suppressed_execution_flag};
      s_nxt.p_start = program_counter == s_r.t_start;
      s_nxt.p_stop  = program_counter == s_r.t_stop;
      s_nxt.p_match = s_r.ctrl[5] ? (dm_valid && dm_addr == s_r.m_addr
                                     && dm_data == s_r.m_val[NB_W-1:0])
                                  : probe_val == s_r.m_val;
      s_nxt.p_ga    = program_counter == s_r.ga_addr;
      s_nxt.p_sqa   = program_counter == s_r.sq_a;
      s_nxt.p_sqb   = program_counter == s_r.sq_b;
      s_nxt.p_gd    = dm_valid && dm_addr == s_r.gd_addr && dm_data == s_r.gd_val;
      s_nxt.p_gp    = probe_val == s_r.gp_val;
      s_nxt.p_nacc  = program_counter > s_r.code_max
                      || (dm_valid && dm_addr > s_r.dm_max);
    end

    // Stage 2: trace decision under the selected mode
    if (s_r.p_v) begin
      case (mode)
        TM_FREE: rec = 1'b1;
        TM_ENB:  rec = attr_rd[1];
        TM_OFF:  rec = 1'b0;
        TM_TRIG: begin
          on_now      = s_r.tr_on || s_r.p_start;
          rec         = on_now;
          s_nxt.tr_on = on_now && !s_r.p_stop;
        end
        TM_POST: begin
          on_now      = s_r.tr_on || s_r.p_match;
          rec         = on_now;
          s_nxt.tr_on = on_now;
        end
        TM_PRE: begin
          rec         = s_r.tr_on;
          s_nxt.tr_on = s_r.tr_on && !s_r.p_match;
        end
        default: rec = 1'b0;
      endcase
      tw_en = rec;
      if (rec) begin
        s_nxt.tptr = s_r.tptr + 1'b1;
        full       = &s_r.tptr;
      end
      if (s_r.p_ga) begin
        s_nxt.ga_hits = hits1[AP_W-1:0];
      end
      if (s_r.p_sqa) begin
        s_nxt.sq_arm = 1'b1;
      end
      g_hit = (s_r.gen[0] && s_r.p_ga && hits1 >= {1'b0, s_r.ga_cnt})
              || (s_r.gen[1] && s_r.p_sqb && s_r.sq_arm)
              || (s_r.gen[2] && s_r.p_gd)
              || (s_r.gen[3] && s_r.p_gp);
    end

    // Machine cycle tally, frozen outside a run
    if (mcyc && s_r.run) begin
      s_nxt.cyc = s_r.cyc + 1'b1;
    end

    // Break sources and masking
    ev[0] = s_r.p_v && attr_rd[0];
    ev[1] = full;
    ev[2] = mcyc && s_r.run && &s_r.cyc;
    ev[3] = ap_ovf[0];
    ev[4] = probe_ext && !s_r.ext_q;
    ev[5] = pwr_dn_set && s_r.run;
    ev[6] = s_r.p_v && s_r.p_nacc;
    ev[7] = g_hit;
    ev_en = ev & {3'b111, s_r.mask};
    if (s_r.run && |ev_en) begin
      s_nxt.run   = 1'b0;
      s_nxt.brk   = 1'b1;
      s_nxt.cause = s_r.cause | ev_en;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Trace memory, 8K entries
  emtbu_mem #(.W(ENT_W), .A(TP_W)) u_trace (
    .mclk  (mclk),
    .we    (tw_en),
    .waddr (s_r.tptr),
    .wdata (s_r.p_ent),
    .raddr (s_r.tidx),
    .rdata (tr_rd)
  );

  // Breakpoint and trace enable bits per code address
  emtbu_mem #(.W(2), .A(PC_W)) u_attr (
    .mclk  (mclk),
    .we    (attr_we),
    .waddr (s_r.cidx),
    .wdata (s_r.wdata[1:0]),
    .raddr (s_r.run ? program_counter : s_r.cidx),
    .rdata (attr_rd)
  );

  // Executed marker bits
  emtbu_mem #(.W(1), .A(PC_W)) u_mark (
    .mclk  (mclk),
    .we    (mark_we),
    .waddr (s_r.run ? program_counter : s_r.cidx),
    .wdata (s_r.run),
    .raddr (s_r.cidx),
    .rdata (mark_rd)
  );

  // Address visit counters
  for (genvar g = 0; g < AP_N; g++) begin : g_ap
    emtbu_pass_ctr u_ap (
      .mclk     (mclk),
      .nrst     (nrst),
      .cfg_we   (ap_we[g]),
      .cfg_addr (s_r.wdata[PC_W-1:0]),
      .step     (step),
      .pc       (program_counter),
      .cnt      (ap_cnt[g]),
      .addr     (ap_addr[g]),
      .ovf      (ap_ovf[g])
    );
  end

  // Outputs straight from state
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign emu_run       = s_r.run;
  assign brk_pulse     = s_r.brk;
endmodule
`default_nettype wire
